// file: design/sdis_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SDIS_REGS_SVH
`define SDIS_REGS_SVH

`define SDIS_CTRL_OFS 8'h00
`define SDIS_CURR_OFS 8'h04
`define SDIS_POS_OFS 8'h08
`define SDIS_STAT_OFS 8'h0c

`define SDIS_MODE_LSB 0
`define SDIS_DIRINV_BIT 2
`define SDIS_RES_LSB 4
`define SDIS_FILT_LSB 16
`define SDIS_RUN_LSB 0
`define SDIS_HOLD_LSB 8

`define SDIS_RES_RESET 5'h13
`define SDIS_RUN_RESET 7'h19
`define SDIS_HOLD_RESET 7'h05

`define SDIS_CLK_NS 100
`define SDIS_FILT_MIN_NS 50
`define SDIS_FILT_MAX_NS 12900
`define SDIS_FILT_MIN_CYC \
    ((`SDIS_FILT_MIN_NS + `SDIS_CLK_NS - 1) / `SDIS_CLK_NS)
`define SDIS_FILT_MAX_CYC (`SDIS_FILT_MAX_NS / `SDIS_CLK_NS)

`define SDIS_FULL_STEP 65536

`endif

// file: design/sdis_pkg.sv
// Types shared by the step input sequencer
`default_nettype none
package sdis_pkg;
    typedef enum logic [1:0] {
        SDIS_STEP_DIR = 2'b00,
        SDIS_QUAD = 2'b01,
        SDIS_UP_DOWN = 2'b10
    } sdis_mode_t;
endpackage
`default_nettype wire

// file: design/sdis_core.sv
// Step/direction input sequencer with AHB-Lite register slave
// How it works
// - Three inputs are taken: step or phase A or count up, heading or phase B or count down, and output allow.
// - While output allow is high the motor driver outputs stay enabled.
// - When output allow is low the motor driver outputs are disabled.
// - The position generator keeps counting steps while the driver is disabled.
// - After reset the two clock inputs are read as step and direction.
// - In step/direction form each rising step edge moves one microstep, way set by heading.
// - The size of each move follows the selected microstep resolution.
// - A setting chooses which heading level means forward.
// - In quadrature form the position follows the master's two phases.
// - In up/down form the inputs are separate forward and backward clocks.
// - Heading and resolution are latched on each rising step edge and held between edges.
// - A heading or resolution change acts only from the next rising step edge.
// - Run and hold current settings act at once.
// - Clock inputs pass a glitch filter of 50 ns up to 12.9 us.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`include "sdis_regs.svh"
`default_nettype none
module sdis_core #(
    parameter int POS_W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic allow_in,
    output logic driver_enable,
    output logic [6:0] run_current,
    output logic [6:0] hold_current,
    output logic [POS_W-1:0] position
);
    if (POS_W < 18 || POS_W > 32) begin : g_bad_width
        $error("POS_W must lie in 18..32");
    end

    // Per-microstep increment, a full step being 65536 fine units
    function automatic logic [16:0] res_incr(input logic [4:0] code);
        unique case (code)
            5'h00: res_incr = 17'(`SDIS_FULL_STEP / 1);
            5'h01: res_incr = 17'(`SDIS_FULL_STEP / 2);
            5'h02: res_incr = 17'(`SDIS_FULL_STEP / 4);
            5'h03: res_incr = 17'(`SDIS_FULL_STEP / 5);
            5'h04: res_incr = 17'(`SDIS_FULL_STEP / 8);
            5'h05: res_incr = 17'(`SDIS_FULL_STEP / 10);
            5'h06: res_incr = 17'(`SDIS_FULL_STEP / 16);
            5'h07: res_incr = 17'(`SDIS_FULL_STEP / 25);
            5'h08: res_incr = 17'(`SDIS_FULL_STEP / 32);
            5'h09: res_incr = 17'(`SDIS_FULL_STEP / 50);
            5'h0a: res_incr = 17'(`SDIS_FULL_STEP / 64);
            5'h0b: res_incr = 17'(`SDIS_FULL_STEP / 100);
            5'h0c: res_incr = 17'(`SDIS_FULL_STEP / 108);
            5'h0d: res_incr = 17'(`SDIS_FULL_STEP / 125);
            5'h0e: res_incr = 17'(`SDIS_FULL_STEP / 127);
            5'h0f: res_incr = 17'(`SDIS_FULL_STEP / 128);
            5'h10: res_incr = 17'(`SDIS_FULL_STEP / 180);
            5'h11: res_incr = 17'(`SDIS_FULL_STEP / 200);
            5'h12: res_incr = 17'(`SDIS_FULL_STEP / 250);
            default: res_incr = 17'(`SDIS_FULL_STEP / 256);
        endcase
    endfunction

    // Bus slave
    logic dp_wr, dp_rd, rd_done;
    logic [7:0] dp_addr;
    wire take = hsel & htrans[1] & hready;
    wire rd_load = dp_rd & ~rd_done;
    wire wr_ctrl = dp_wr && dp_addr == `SDIS_CTRL_OFS;
    wire wr_curr = dp_wr && dp_addr == `SDIS_CURR_OFS;
    // One wait state on reads so a preceding write is always visible
    assign hreadyout = ~rd_load;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            rd_done <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hreadyout) begin
            dp_wr <= take & hwrite;
            dp_rd <= take & ~hwrite;
            rd_done <= 1'b0;
            dp_addr <= take ? haddr[7:0] : 8'h00;
        end else begin
            rd_done <= 1'b1;
        end
    end

    // Configuration
    sdis_pkg::sdis_mode_t mode;
    logic dir_inv;
    logic [4:0] res_code;
    logic [7:0] filt_cfg;
    logic ctrl_touched;
    wire [1:0] wmode = hwdata[`SDIS_MODE_LSB +: 2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= sdis_pkg::SDIS_STEP_DIR;
            dir_inv <= 1'b0;
            res_code <= `SDIS_RES_RESET;
            filt_cfg <= 8'(`SDIS_FILT_MIN_CYC);
            ctrl_touched <= 1'b0;
        end else if (wr_ctrl) begin
            // Reserved mode code falls back to step/direction
            mode <= wmode == 2'b11 ? sdis_pkg::SDIS_STEP_DIR
                                   : sdis_pkg::sdis_mode_t'(wmode);
            dir_inv <= hwdata[`SDIS_DIRINV_BIT];
            res_code <= hwdata[`SDIS_RES_LSB +: 5];
            filt_cfg <= hwdata[`SDIS_FILT_LSB +: 8];
            ctrl_touched <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_current <= `SDIS_RUN_RESET;
            hold_current <= `SDIS_HOLD_RESET;
        end else if (wr_curr) begin
            // No wait for a step edge
            run_current <= hwdata[`SDIS_RUN_LSB +: 7];
            hold_current <= hwdata[`SDIS_HOLD_LSB +: 7];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            driver_enable <= 1'b0;
        end else begin
            driver_enable <= allow_in;
        end
    end

    // Glitch filter: a level must hold filt_need cycles to pass
    wire [7:0] filt_need =
        filt_cfg < 8'(`SDIS_FILT_MIN_CYC) ? 8'(`SDIS_FILT_MIN_CYC) :
        filt_cfg > 8'(`SDIS_FILT_MAX_CYC) ? 8'(`SDIS_FILT_MAX_CYC) :
        filt_cfg;
    wire [1:0] raw = {phase_b_in, phase_a_in};
    logic [1:0] filt, prev;
    logic [7:0] fcnt [2];

    for (genvar i = 0; i < 2; i++) begin : g_filt
        wire differs = raw[i] != filt[i];
        wire pass = differs && fcnt[i] + 8'h01 >= filt_need;
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                filt[i] <= 1'b0;
                fcnt[i] <= 8'h00;
            end else begin
                filt[i] <= pass ? raw[i] : filt[i];
                fcnt[i] <= differs && !pass ? fcnt[i] + 8'h01 : 8'h00;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= 2'b00;
        end else begin
            prev <= filt;
        end
    end

    // Event decode
    wire a_rise = filt[0] & ~prev[0];
    wire b_rise = filt[1] & ~prev[1];
    wire a_chg = filt[0] ^ prev[0];
    wire b_chg = filt[1] ^ prev[1];
    wire sd_ev = mode == sdis_pkg::SDIS_STEP_DIR && a_rise;
    wire qd_ev = mode == sdis_pkg::SDIS_QUAD && (a_chg ^ b_chg);
    wire ud_ev = mode == sdis_pkg::SDIS_UP_DOWN && (a_rise ^ b_rise);
    // Forward when A leads B, back when B leads A
    wire qd_fwd = filt[0] ^ prev[1];
    wire raw_fwd = sd_ev ? filt[1] : qd_ev ? qd_fwd : a_rise;
    wire step_ev = sd_ev | qd_ev | ud_ev;
    wire step_fwd = raw_fwd ^ dir_inv;
    // Resolution used is the value present at the qualifying edge
    wire [POS_W-1:0] incr = POS_W'(res_incr(res_code));

    logic lat_dir;
    logic [4:0] lat_res;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lat_dir <= 1'b0;
            lat_res <= `SDIS_RES_RESET;
        end else if (sd_ev) begin
            lat_dir <= step_fwd;
            lat_res <= res_code;
        end
    end

    // Position keeps counting regardless of driver_enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            position <= '0;
        end else if (step_ev) begin
            position <= step_fwd ? position + incr : position - incr;
        end
    end

    // Register read
    wire [31:0] rd_mux =
        dp_addr == `SDIS_CTRL_OFS ? {8'h00, filt_cfg, 7'h00, res_code,
                                     1'b0, dir_inv, mode} :
        dp_addr == `SDIS_CURR_OFS ? {17'h00000, hold_current, 1'b0,
                                     run_current} :
        dp_addr == `SDIS_POS_OFS ? 32'(position) :
        dp_addr == `SDIS_STAT_OFS ? {22'h000000, filt, 1'b0, lat_res,
                                     lat_dir, driver_enable} :
        32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_load) begin
            hrdata <= rd_mux;
        end
    end

    // Checks
    chk_drv_on_high: assert property (@(posedge hclk)
        disable iff (!hresetn) allow_in |=> driver_enable)
        else $error("driver not enabled after allow high");
    chk_drv_off_low: assert property (@(posedge hclk)
        disable iff (!hresetn) !allow_in |=> !driver_enable)
        else $error("driver not disabled after allow low");
    chk_pos_while_off: assert property (@(posedge hclk)
        disable iff (!hresetn) (!driver_enable && step_ev)
        |=> position != $past(position))
        else $error("position frozen while driver off");
    chk_default_mode: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !ctrl_touched |-> mode == sdis_pkg::SDIS_STEP_DIR)
        else $error("mode not step/direction by default");
    chk_step_moves: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (mode == sdis_pkg::SDIS_STEP_DIR && a_rise && !dir_inv)
        |=> position == ($past(filt[1]) ? $past(position) + $past(incr)
                                       : $past(position) - $past(incr)))
        else $error("step edge did not move by one microstep");
    chk_step_size: assert property (@(posedge hclk)
        disable iff (!hresetn) step_ev ##1 1'b1
        |-> (position - $past(position, 1) == POS_W'(res_incr(lat_res))
        || $past(position, 1) - position == POS_W'(res_incr(lat_res)))
        || !$past(sd_ev))
        else $error("step size not per resolution");
    chk_latch_hold: assert property (@(posedge hclk)
        disable iff (!hresetn) !sd_ev |=> $stable(lat_dir) && $stable(lat_res))
        else $error("heading or resolution changed between edges");
    chk_latch_take: assert property (@(posedge hclk)
        disable iff (!hresetn) sd_ev
        |=> lat_res == $past(res_code) && lat_dir == $past(step_fwd))
        else $error("edge did not latch heading and resolution");
    chk_current_now: assert property (@(posedge hclk)
        disable iff (!hresetn) wr_curr
        |=> run_current == $past(hwdata[6:0])
        && hold_current == $past(hwdata[14:8]))
        else $error("current setting not applied at once");
    chk_filter_len: assert property (@(posedge hclk)
        disable iff (!hresetn) filt[0] != $past(filt[0])
        |-> $past(fcnt[0]) + 8'h01 >= $past(filt_need))
        else $error("glitch filter passed a short pulse");
    chk_quad_dir: assert property (@(posedge hclk)
        disable iff (!hresetn) (qd_ev && !dir_inv && a_rise && !filt[1])
        |=> position == $past(position) + $past(incr))
        else $error("A leading B did not count forward");
    chk_updown_dir: assert property (@(posedge hclk)
        disable iff (!hresetn) (ud_ev && !dir_inv && b_rise)
        |=> position == $past(position) - $past(incr))
        else $error("count-down rise did not subtract");

    // Bus handshake: reads take exactly one wait state
    chk_rd_wait:
        assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_rd && !rd_done) |-> !hreadyout)
        else $error("read data phase did not insert a wait state");

    chk_rd_one_wait:
        assert property (@(posedge hclk) disable iff (!hresetn)
        rd_load |=> hreadyout)
        else $error("read wait state lasted more than one cycle");

    chk_resp_okay:
        assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == 1'b0)
        else $error("bus response not okay");

    chk_filter_len_b: assert property (@(posedge hclk)
        disable iff (!hresetn) filt[1] != $past(filt[1])
        |-> $past(fcnt[1]) + 8'h01 >= $past(filt_need))
        else $error("glitch filter passed a short pulse on B");

    chk_pos_stands: assert property (@(posedge hclk)
        disable iff (!hresetn) !step_ev |=> $stable(position))
        else $error("position moved without a step event");

    chk_quad_back: assert property (@(posedge hclk)
        disable iff (!hresetn) (qd_ev && !dir_inv && b_rise && !filt[0])
        |=> position == $past(position) - $past(incr))
        else $error("B leading A did not count back");

    chk_quad_follow: assert property (@(posedge hclk)
        disable iff (!hresetn) qd_ev |=> position != $past(position))
        else $error("quadrature change not followed");

    chk_updown_up: assert property (@(posedge hclk)
        disable iff (!hresetn) (ud_ev && !dir_inv && a_rise)
        |=> position == $past(position) + $past(incr))
        else $error("count-up rise did not add");

    chk_ud_both: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (mode == sdis_pkg::SDIS_UP_DOWN && a_rise && b_rise)
        |=> $stable(position))
        else $error("simultaneous up and down rises moved position");

    chk_mode_legal: assert property (@(posedge hclk)
        disable iff (!hresetn) mode != sdis_pkg::sdis_mode_t'(2'b11))
        else $error("reserved mode code stored");

    chk_dir_inv: assert property (@(posedge hclk)
        disable iff (!hresetn) (sd_ev && dir_inv)
        |=> position == ($past(filt[1]) ? $past(position) - $past(incr)
                                       : $past(position) + $past(incr)))
        else $error("inverted heading moved the wrong way");

    chk_res_take: assert property (@(posedge hclk)
        disable iff (!hresetn) wr_ctrl
        |=> res_code == $past(hwdata[8:4]))
        else $error("resolution setting not stored");
endmodule
`default_nettype wire

// file: bench/sdis_ctrl_model.sv
// Motion controller model driving the step, heading and allow lines
`default_nettype none
module sdis_ctrl_model (
    input wire logic clk,
    output logic phase_a,
    output logic phase_b,
    output logic allow
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        allow = 1'b1;
    end
    // Levels change just after an edge, then stand for hold edges
    task automatic set_lines(input logic a, input logic b, input int hold);
        @(posedge clk);
        phase_a <= a;
        phase_b <= b;
        repeat (hold) @(posedge clk);
    endtask
    task automatic set_allow(input logic en);
        @(posedge clk);
        allow <= en;
    endtask
endmodule
`default_nettype wire

// file: bench/test_sdis_core.sv
// Self-checking bench for the step input sequencer
`include "sdis_regs.svh"
`default_nettype none
module test_sdis_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [31:0] p0;
    wire pa;
    wire pb;
    wire al;
    logic driver_enable;
    logic [6:0] run_current;
    logic [6:0] hold_current;
    logic [31:0] position;
    int error_cnt = 0;
    int n_checks = 0;
    always #50 hclk = ~hclk;
    sdis_ctrl_model u_sdis_ctrl_model (.clk(hclk), .phase_a(pa),
        .phase_b(pb), .allow(al));
    sdis_core u_sdis_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .phase_a_in(pa), .phase_b_in(pb),
        .allow_in(al), .driver_enable(driver_enable),
        .run_current(run_current), .hold_current(hold_current),
        .position(position));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Mid-cycle look avoids racing the combinational ready at the edge
    task automatic wait_rdy();
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask
    task automatic ahb_addr(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
    endtask
    task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
        ahb_addr(a, 1'b1);
        hwdata <= d;
        wait_rdy();
    endtask
    task automatic ahb_rd(input logic [31:0] a, output logic [31:0] d);
        ahb_addr(a, 1'b0);
        wait_rdy();
        d = hrdata;
    endtask
    // Heading set while step is low, then one full step pulse
    task automatic step(input logic h);
        u_sdis_ctrl_model.set_lines(1'b0, h, 2);
        u_sdis_ctrl_model.set_lines(1'b1, h, 4);
        u_sdis_ctrl_model.set_lines(1'b0, h, 4);
        @(negedge hclk);
    endtask
    task automatic pulse(input logic a, input logic b);
        u_sdis_ctrl_model.set_lines(a, b, 4);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b0, 4);
        @(negedge hclk);
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        ahb_rd(`SDIS_CTRL_OFS, rd);
        check("ctrl", rd, 32'h00010130);
        ahb_rd(`SDIS_CURR_OFS, rd);
        check("current", rd, 32'h00000519);
        ahb_rd(32'h40, rd);
        check("unmapped", rd, 32'h0);
        check("drv_en", {31'h0, driver_enable}, 32'h1);
        $display("test reset done");
        step(1'b1);
        check("pos fwd", position, 32'h100);
        ahb_rd(`SDIS_STAT_OFS, rd);
        check("lat head", rd & 32'h2, 32'h2);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b0, 4);
        check("pos stands", position, 32'h100);
        ahb_rd(`SDIS_STAT_OFS, rd);
        check("head held", rd & 32'h2, 32'h2);
        step(1'b0);
        check("pos back", position, 32'h0);
        ahb_wr(`SDIS_CTRL_OFS, 32'h00010000);
        step(1'b1);
        check("res full", position, 32'h10000);
        ahb_wr(`SDIS_CTRL_OFS, 32'h00010004);
        step(1'b1);
        check("dir inv", position, 32'h0);
        $display("test step/dir done");
        u_sdis_ctrl_model.set_allow(1'b0);
        repeat (2) @(negedge hclk);
        check("drv off", {31'h0, driver_enable}, 32'h0);
        step(1'b0);
        check("pos disabled", position, 32'h10000);
        u_sdis_ctrl_model.set_allow(1'b1);
        ahb_wr(`SDIS_CURR_OFS, 32'h00000a3c);
        @(negedge hclk);
        check("run cur", {25'h0, run_current}, 32'h3c);
        check("hold cur", {25'h0, hold_current}, 32'h0a);
        $display("test enable/current done");
        ahb_wr(`SDIS_CTRL_OFS, 32'h00030000);
        u_sdis_ctrl_model.set_lines(1'b1, 1'b1, 1);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b1, 6);
        check("glitch", position, 32'h10000);
        step(1'b1);
        check("filt pass", position, 32'h20000);
        ahb_wr(`SDIS_CTRL_OFS, 32'h00030002);
        pulse(1'b1, 1'b0);
        check("count up", position, 32'h30000);
        pulse(1'b0, 1'b1);
        check("count down", position, 32'h20000);
        ahb_wr(`SDIS_CTRL_OFS, 32'h00030001);
        p0 = position;
        u_sdis_ctrl_model.set_lines(1'b1, 1'b0, 4);
        u_sdis_ctrl_model.set_lines(1'b1, 1'b1, 4);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b1, 4);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b0, 4);
        @(negedge hclk);
        check("quad fwd", position, p0 + 32'h00040000);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b1, 4);
        u_sdis_ctrl_model.set_lines(1'b1, 1'b1, 4);
        u_sdis_ctrl_model.set_lines(1'b1, 1'b0, 4);
        u_sdis_ctrl_model.set_lines(1'b0, 1'b0, 4);
        @(negedge hclk);
        check("quad back", position, p0);
        $display("test modes done");
        ahb_rd(`SDIS_POS_OFS, rd);
        check("pos reg", rd, p0);
        ahb_wr(`SDIS_POS_OFS, 32'h00001234);
        ahb_rd(`SDIS_POS_OFS, rd);
        check("pos ro", rd, p0);
        ahb_rd(`SDIS_STAT_OFS, rd);
        check("status", rd, 32'h00000003);
        ahb_wr(`SDIS_CTRL_OFS, 32'h00010003);
        ahb_rd(`SDIS_CTRL_OFS, rd);
        check("mode rsvd", rd, 32'h00010000);
        check("okay", {31'h0, hresp}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        check("pos reset", position, 32'h0);
        ahb_rd(`SDIS_CURR_OFS, rd);
        check("cur reset", rd, 32'h00000519);
        step(1'b1);
        check("pos after rst", position, 32'h100);
        $display("test regs and reset done");
        conclude();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
